// ### lag_tracker.v
// link aggregation member tracking, flow hashing and flap counting
`timescale 1ns/1ps
`include "lag_map.vh"
module lag_tracker (
	// clock and reset
	input wire clk,
	input wire rst,
	// axi4-lite write
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// physical port state
	input wire [15:0] link_up,
	input wire [15:0] oper_en,
	// egress flow request
	input wire tx_valid,
	input wire [1:0] tx_channel,
	input wire [47:0] src_mac,
	input wire [47:0] dst_mac,
	input wire [11:0] vlan,
	input wire [15:0] ethertype,
	input wire [3:0] in_port,
	input wire [31:0] src_ip,
	input wire [31:0] dst_ip,
	input wire [15:0] src_l4,
	input wire [15:0] dst_l4,
	// egress decision
	output reg tx_out_valid,
	output reg [3:0] tx_out_port,
	output reg tx_out_drop,
	// ingress check
	input wire rx_valid,
	input wire [3:0] rx_port,
	input wire rx_lacp,
	output reg rx_accept,
	output reg rx_drop,
	// lacp permission and interrupt
	output reg [15:0] lacp_en,
	output reg irq
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	reg [31:0] irq_stat;
	reg [31:0] irq_mask;
	reg [15:0] port_admin;
	reg [31:0] ch_cfg;
	reg [15:0] member;
	reg [1:0] chan_of [0:15];
	reg cmd_rej;
	reg clr_cnt;
	reg [15:0] prev_up;
	reg [3:0] prev_has;
	reg [3:0] prev_ch_admin;
	reg [15:0] active_q;
	wire [15:0] port_cnt [0:15];
	wire [15:0] ch_cnt [0:3];

	// ---------------------------------------------------------------
	// combinational status
	// ---------------------------------------------------------------
	reg [15:0] active;
	reg [15:0] port_up;
	reg [15:0] mflap;
	reg [3:0] ch_admin;
	reg [3:0] ch_static;
	reg [3:0] ch_has;
	reg [3:0] cflap;
	reg [15:0] ch_members;
	integer p;
	integer c;
	integer pw;
	integer pl;
	integer ph;

	always @* begin
		active = 16'h0000;
		port_up = 16'h0000;
		ch_members = 16'h0000;
		ch_has = 4'h0;
		for (c = 0; c < `NCH; c = c + 1) begin
			ch_admin[c] = ch_cfg[8*c+`CFG_ADMIN_BIT];
			ch_static[c] = ch_cfg[8*c+`CFG_STATIC_BIT];
		end
		for (p = 0; p < `NPORT; p = p + 1) begin
			active[p] = member[p] & oper_en[p] & port_admin[p] & link_up[p];
			port_up[p] = port_admin[p] & link_up[p];
			if (member[p]) begin
				ch_members[4*chan_of[p] +: 4] =
					ch_members[4*chan_of[p] +: 4] + 4'h1;
			end
			if (active[p]) begin
				ch_has[chan_of[p]] = 1'b1;
			end
		end
		mflap = prev_up & ~port_up;
		cflap = (prev_ch_admin & ~ch_admin) |
			(prev_has & ~ch_has & ch_admin);
	end

	// ---------------------------------------------------------------
	// member join check
	// ---------------------------------------------------------------
	wire [3:0] cmd_port = s_axi_wdata[3:0];
	wire [1:0] cmd_ch = s_axi_wdata[`CMD_CH_LSB +: 2];
	wire cmd_join = s_axi_wdata[`CMD_JOIN_BIT];
	reg [3:0] target_cnt;
	reg join_reject;

	always @* begin
		target_cnt = ch_members[4*cmd_ch +: 4];
		if (member[cmd_port] && chan_of[cmd_port] == cmd_ch) begin
			target_cnt = target_cnt - 4'h1;
		end
		join_reject = cmd_join && target_cnt >= `MAX_MEMBERS;
	end

	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer b;
		begin
			for (b = 0; b < 4; b = b + 1) begin
				merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
			end
		end
	endfunction

	wire wr_go = s_axi_awready;
	wire [31:0] admin_merged = merge({16'h0000, port_admin}, s_axi_wdata,
		s_axi_wstrb);
	wire [31:0] set_bits = {29'h0000_0000, 1'b0, 1'b0, 1'b0} |
		({31'h0000_0000, |mflap} << `IRQ_MFLAP_BIT) |
		({31'h0000_0000, |cflap} << `IRQ_CFLAP_BIT) |
		({31'h0000_0000, wr_go && s_axi_awaddr == `OFF_MEMBER_CMD &&
		join_reject} << `IRQ_REJECT_BIT);
	reg [31:0] w1c;
	wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
		{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

	always @* begin
		w1c = 32'h0000_0000;
		if (wr_go && s_axi_awaddr == `OFF_IRQ_STAT) begin
			w1c = s_axi_wdata & wmask;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			irq_stat <= 32'h0000_0000;
			irq_mask <= `RST_IRQ_MASK;
			port_admin <= `RST_PORT_ADMIN;
			ch_cfg <= `RST_CH_CFG;
			member <= 16'h0000;
			cmd_rej <= 1'b0;
			clr_cnt <= 1'b0;
			for (pw = 0; pw < `NPORT; pw = pw + 1) begin
				chan_of[pw] <= 2'h0;
			end
		end else begin
			s_axi_awready <= !s_axi_awready && s_axi_awvalid &&
				s_axi_wvalid && !s_axi_bvalid;
			s_axi_wready <= !s_axi_awready && s_axi_awvalid &&
				s_axi_wvalid && !s_axi_bvalid;
			clr_cnt <= 1'b0;
			// hardware set wins over a same-cycle clear
			irq_stat <= (irq_stat & ~w1c) | set_bits;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				case (s_axi_awaddr)
				`OFF_CTRL: begin
					clr_cnt <= s_axi_wstrb[0] &&
						s_axi_wdata[`CTRL_CLR_BIT];
				end
				`OFF_IRQ_STAT: begin
				end
				`OFF_IRQ_MASK: begin
					irq_mask <= merge(irq_mask, s_axi_wdata, s_axi_wstrb);
				end
				`OFF_PORT_ADMIN: begin
					port_admin <= admin_merged[15:0];
				end
				`OFF_CH_CFG: begin
					ch_cfg <= merge(ch_cfg, s_axi_wdata, s_axi_wstrb);
				end
				`OFF_MEMBER_CMD: begin
					cmd_rej <= join_reject;
					if (!join_reject) begin
						member[cmd_port] <= cmd_join;
						if (cmd_join) begin
							chan_of[cmd_port] <= cmd_ch;
						end
					end
				end
				default: begin
					s_axi_bresp <= `RESP_SLVERR;
				end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// register reads
	// ---------------------------------------------------------------
	reg [31:0] rd_mux;
	reg rd_err;
	wire [3:0] rd_port = s_axi_araddr[5:2] - 4'h8;
	wire [1:0] rd_ch = s_axi_araddr[3:2];

	always @* begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		if (s_axi_araddr >= `OFF_PORT_BASE &&
			s_axi_araddr <= `OFF_PORT_LAST) begin
			rd_mux = {13'h0000, member[rd_port], chan_of[rd_port],
				port_cnt[rd_port]};
		end else if (s_axi_araddr >= `OFF_CH_BASE &&
			s_axi_araddr <= `OFF_CH_LAST) begin
			rd_mux = {12'h000, ch_members[4*rd_ch +: 4], ch_cnt[rd_ch]};
		end else begin
			case (s_axi_araddr)
			`OFF_CTRL: rd_mux = 32'h0000_0000;
			`OFF_IRQ_STAT: rd_mux = irq_stat;
			`OFF_IRQ_MASK: rd_mux = irq_mask;
			`OFF_PORT_ADMIN: rd_mux = {16'h0000, port_admin};
			`OFF_CH_CFG: rd_mux = ch_cfg;
			`OFF_MEMBER_CMD: rd_mux = {cmd_rej, 15'h0000, member};
			`OFF_ACTIVE: rd_mux = {16'h0000, active_q};
			default: rd_err = 1'b1;
			endcase
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid &&
				!s_axi_rvalid;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_err ? 32'h0000_0000 : rd_mux;
				s_axi_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
			end
		end
	end

	// ---------------------------------------------------------------
	// flap counters
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `NPORT; g = g + 1) begin : port_flap
			flap_counter u_cnt (
				.clk(clk),
				.rst(rst),
				.clr(clr_cnt),
				.down_event(mflap[g]),
				.count(port_cnt[g])
			);
		end
		for (g = 0; g < `NCH; g = g + 1) begin : ch_flap
			flap_counter u_cnt (
				.clk(clk),
				.rst(rst),
				.clr(clr_cnt),
				.down_event(cflap[g]),
				.count(ch_cnt[g])
			);
		end
	endgenerate

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_up <= 16'h0000;
			prev_has <= 4'h0;
			prev_ch_admin <= 4'h0;
			active_q <= 16'h0000;
			irq <= 1'b0;
			lacp_en <= 16'h0000;
		end else begin
			prev_up <= port_up;
			prev_has <= ch_has;
			prev_ch_admin <= ch_admin;
			active_q <= active;
			irq <= |(irq_stat & irq_mask);
			for (pl = 0; pl < `NPORT; pl = pl + 1) begin
				lacp_en[pl] <= member[pl] && !ch_static[chan_of[pl]] &&
					ch_admin[chan_of[pl]];
			end
		end
	end

	// ---------------------------------------------------------------
	// flow hash and member selection
	// ---------------------------------------------------------------
	function [7:0] fold8;
		input [63:0] x;
		integer i;
		begin
			fold8 = 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				fold8 = fold8 ^ x[8*i +: 8];
			end
		end
	endfunction

	wire [7:0] l2_tail = fold8({20'h00000, vlan, ethertype, 12'h000, in_port});
	reg [7:0] hash;
	reg [3:0] n_act;
	reg [2:0] pick;
	reg [7:0] hmod;
	reg [3:0] rank;
	reg [3:0] sel_port;
	reg found;
	wire [2:0] hsel = ch_cfg[8*tx_channel+`CFG_HASH_LSB +: 3];

	always @*begin
		case (hsel)
		`HASH_SMAC: hash = fold8({16'h0000, src_mac}) ^ l2_tail;
		`HASH_DMAC: hash = fold8({16'h0000, dst_mac}) ^ l2_tail;
		`HASH_SDMAC: hash = fold8({16'h0000, src_mac}) ^
			fold8({16'h0000, dst_mac}) ^ l2_tail;
		`HASH_SIP: hash = fold8({16'h0000, src_ip, src_l4});
		`HASH_DIP: hash = fold8({16'h0000, dst_ip, dst_l4});
		`HASH_SDIP: hash = fold8({src_ip, dst_ip}) ^
			fold8({32'h0000_0000, src_l4, dst_l4});
		default: hash = fold8({16'h0000, src_mac}) ^ l2_tail;
		endcase
		n_act = 4'h0;
		for (ph = 0; ph < `NPORT; ph = ph + 1) begin
			if (active[ph] && chan_of[ph] == tx_channel) begin
				n_act = n_act + 4'h1;
			end
		end
		hmod = 8'h00;
		if (n_act != 4'h0) begin
			hmod = hash % {4'h0, n_act};
		end
		// at most eight active members, so the remainder fits
		pick = hmod[2:0];
		rank = 4'h0;
		sel_port = 4'h0;
		found = 1'b0;
		for (ph = 0; ph < `NPORT; ph = ph + 1) begin
			if (active[ph] && chan_of[ph] == tx_channel) begin
				if (!found && rank == {1'b0, pick}) begin
					sel_port = ph[3:0];
					found = 1'b1;
				end
				rank = rank + 4'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// egress and ingress decisions
	// ---------------------------------------------------------------
	wire rx_chan_on = ch_admin[chan_of[rx_port]];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_out_valid <= 1'b0;
			tx_out_port <= 4'h0;
			tx_out_drop <= 1'b0;
			rx_accept <= 1'b0;
			rx_drop <= 1'b0;
		end else begin
			tx_out_valid <= tx_valid;
			tx_out_port <= sel_port;
			tx_out_drop <= tx_valid && (!ch_admin[tx_channel] || !found);
			rx_accept <= 1'b0;
			rx_drop <= 1'b0;
			if (rx_valid) begin
				if (!member[rx_port]) begin
					rx_accept <= !rx_lacp;
					rx_drop <= rx_lacp;
				end else if (!rx_chan_on || !active[rx_port] ||
					(rx_lacp && ch_static[chan_of[rx_port]])) begin
					rx_drop <= 1'b1;
				end else begin
					rx_accept <= 1'b1;
				end
			end
		end
	end

endmodule

// ### lag_map.vh
// register offsets, field positions and reset values of the lag tracker
`ifndef LAG_MAP_VH
`define LAG_MAP_VH

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define NPORT 16
`define NCH 4
`define MAX_MEMBERS 4'h8
`define CNT_W 16

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_IRQ_STAT 8'h04
`define OFF_IRQ_MASK 8'h08
`define OFF_PORT_ADMIN 8'h0C
`define OFF_CH_CFG 8'h10
`define OFF_MEMBER_CMD 8'h14
`define OFF_ACTIVE 8'h18
`define OFF_PORT_BASE 8'h20
`define OFF_PORT_LAST 8'h5C
`define OFF_CH_BASE 8'h60
`define OFF_CH_LAST 8'h6C

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTRL_CLR_BIT 0
`define IRQ_MFLAP_BIT 0
`define IRQ_CFLAP_BIT 1
`define IRQ_REJECT_BIT 2
`define CFG_ADMIN_BIT 0
`define CFG_STATIC_BIT 1
`define CFG_HASH_LSB 2
`define CMD_CH_LSB 4
`define CMD_JOIN_BIT 8
`define CMD_REJ_BIT 31

// ---------------------------------------------------------------
// hash key sets
// ---------------------------------------------------------------
`define HASH_SMAC 3'h0
`define HASH_DMAC 3'h1
`define HASH_SDMAC 3'h2
`define HASH_SIP 3'h3
`define HASH_DIP 3'h4
`define HASH_SDIP 3'h5

// ---------------------------------------------------------------
// reset values and bus answers
// ---------------------------------------------------------------
`define RST_IRQ_MASK 32'h0000_0000
`define RST_PORT_ADMIN 16'hFFFF
`define RST_CH_CFG 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### flap_counter.v
// saturating flap counter with a synchronous clear
`timescale 1ns/1ps
module flap_counter (
	// clock and reset
	input wire clk,
	input wire rst,
	// control
	input wire clr,
	input wire down_event,
	// count
	output reg [15:0] count
);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= 16'h0000;
		end else if (clr) begin
			count <= 16'h0000;
		end else if (down_event && count != 16'hFFFF) begin
			count <= count + 16'h0001;
		end
	end

endmodule

// ### lag_checker.sv
// port-level assertions for the lag tracker
`timescale 1ns/1ps
module lag_checker (
	// clock and reset
	input wire clk,
	input wire rst,
	// register bus
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	// traffic
	input wire [15:0] oper_en,
	input wire tx_valid,
	input wire tx_out_valid,
	input wire tx_out_drop,
	input wire rx_valid,
	input wire [3:0] rx_port,
	input wire rx_lacp,
	input wire rx_accept,
	input wire rx_drop,
	input wire [15:0] lacp_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_TX_ECHO:
	assert property (tx_out_valid == $past(tx_valid))
		else $error("egress answer missing");
	AST_DROP_VALID:
	assert property (tx_out_drop |-> tx_out_valid)
		else $error("drop without answer");
	AST_NO_OPER:
	assert property (tx_valid && oper_en == 16'h0000
		&& $past(oper_en) == 16'h0000 |=> tx_out_drop)
		else $error("egress sent with no port enabled");
	AST_RX_ONE:
	assert property (rx_valid |=> rx_accept != rx_drop)
		else $error("ingress answer not exactly one");
	AST_RX_LACP:
	assert property (rx_valid && rx_lacp && !lacp_en[rx_port]
		|=> rx_drop || $changed(lacp_en))
		else $error("control frame accepted on port without it");
	AST_AW_TAKE:
	assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
		&& !s_axi_bvalid |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid)
		else $error("write not taken in time");
	AST_AR_TAKE:
	assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
		|=> s_axi_arready ##1 s_axi_rvalid)
		else $error("read not taken in time");
	AST_B_HOLD:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped early");
endmodule

// ### link_partner.sv
// link partner model: link state of the sixteen ports
`timescale 1ns/1ps
module link_partner (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// requested drops and link state
	input wire logic [15:0] down_req,
	output logic [15:0] link_up
);
	logic [15:0] train;
	// a dropped link falls at once and needs two cycles to retrain
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			train <= 16'hFFFF;
			link_up <= 16'hFFFF;
		end else begin
			train <= ~down_req;
			link_up <= train & ~down_req;
		end
	end
endmodule

// ### tb_top.sv
// self-checking bench of the lag tracker
`timescale 1ns/1ps
`include "lag_map.vh"
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, seed, src_ip, dst_ip;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp, tx_channel;
	logic [15:0] oper_en, down_req, link_up, lacp_en;
	logic [47:0] src_mac, dst_mac;
	logic [15:0] ethertype, src_l4, dst_l4;
	logic [11:0] vlan;
	logic [3:0] in_port, rx_port, tx_out_port, wstrb;
	logic tx_valid, rx_valid, rx_lacp;
	logic tx_out_valid, tx_out_drop, rx_accept, rx_drop, irq;
	logic [6:0] res, first;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			end_sim();
		end
	end
	link_partner i_link_partner (.clk(clk), .rst(rst), .down_req(down_req),
		.link_up(link_up));
	lag_tracker i_lag_tracker (
		.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.link_up(link_up), .oper_en(oper_en), .tx_valid(tx_valid),
		.tx_channel(tx_channel), .src_mac(src_mac), .dst_mac(dst_mac),
		.vlan(vlan), .ethertype(ethertype), .in_port(in_port),
		.src_ip(src_ip), .dst_ip(dst_ip), .src_l4(src_l4), .dst_l4(dst_l4),
		.tx_out_valid(tx_out_valid), .tx_out_port(tx_out_port),
		.tx_out_drop(tx_out_drop), .rx_valid(rx_valid), .rx_port(rx_port),
		.rx_lacp(rx_lacp), .rx_accept(rx_accept), .rx_drop(rx_drop),
		.lacp_en(lacp_en), .irq(irq));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expected port record: count, channel 0, member flag
	function automatic logic [31:0] pword(input logic [15:0] n,
		input logic mem);
		return {13'h0000, mem, 2'h0, n};
	endfunction
	function automatic logic [31:0] cfg(input logic en, input logic st,
		input logic [2:0] h);
		return {27'h000_0000, h, st, en};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		if (err_total == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk);
		{awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			aw_ok |= awready;
			w_ok |= wready;
		end
		repeat (rnd() % 3) @(posedge clk);
		bready <= 1'b1;
		do @(posedge clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		{araddr, arvalid} <= {a, 1'b1};
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		repeat (rnd() % 3) @(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (rvalid !== 1'b1);
		resp = rresp;
		rready <= 1'b0;
		chk(rdata, exp);
	endtask
	// one egress and one ingress query together
	task automatic q(input logic [1:0] ch, input logic [3:0] p,
		input logic lacp);
		@(posedge clk);
		{tx_channel, rx_port, rx_lacp, tx_valid, rx_valid} <= {ch, p, lacp, 2'b11};
		@(posedge clk);
		{tx_valid, rx_valid} <= 2'b00;
		@(posedge clk);
		chk(32'(tx_out_valid), 32'h0000_0001);
		res = {rx_accept, rx_drop, tx_out_drop, tx_out_port};
	endtask
	task automatic shuffle(input logic mac_side);
		if (mac_side)
			{src_mac, dst_mac, vlan, ethertype, in_port} <= {rnd(), rnd(),
				rnd(), rnd()};
		else
			{src_ip, dst_ip, src_l4, dst_l4} <= {rnd(), rnd(), rnd()};
	endtask
	initial begin
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		{tx_channel, down_req, tx_valid, rx_valid, rx_lacp, rx_port} = '0;
		{src_mac, dst_mac, vlan, ethertype, in_port} = '0;
		{src_ip, dst_ip, src_l4, dst_l4} = '0;
		oper_en = 16'hFFFF;
		wstrb = 4'hF;
		seed = 32'h2fd3_deb2;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rc(`OFF_PORT_ADMIN, {16'h0000, `RST_PORT_ADMIN});
		rc(`OFF_CH_CFG, `RST_CH_CFG);
		rc(`OFF_IRQ_MASK, `RST_IRQ_MASK);
		rc(8'h1C, 32'h0000_0000);
		chk(32'(resp), 32'(`RESP_SLVERR));
		wr(8'hF0, 32'h0000_0001);
		chk(32'(resp), 32'(`RESP_SLVERR));
		// no byte lane enabled: the mask must keep its value
		wstrb <= 4'h0;
		wr(`OFF_IRQ_MASK, 32'h0000_0004);
		rc(`OFF_IRQ_MASK, `RST_IRQ_MASK);
		wstrb <= 4'hF;
		wr(`OFF_IRQ_MASK, 32'h0000_0004);
		for (int p = 0; p < 9; p++)
			wr(`OFF_MEMBER_CMD, {23'h00_0000, 9'h100 | 9'(p)});
		rc(`OFF_MEMBER_CMD, 32'h8000_00FF);
		rc(`OFF_CH_BASE, 32'h0008_0000);
		chk(32'(irq), 32'h0000_0001);
		wr(`OFF_IRQ_STAT, 32'h0000_0004);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0000_0000);
		for (int h = 0; h < 6; h++) begin
			wr(`OFF_CH_CFG, cfg(1'b1, 1'b0, 3'(h)));
			shuffle(1'b1);
			shuffle(1'b0);
			q(2'h0, 4'(h), 1'b1);
			first = res;
			chk(32'(res[6:3]), 32'h0000_0008);
			// change only fields outside the key set
			shuffle(h > 2);
			q(2'h0, 4'(h), 1'b1);
			chk(32'(res), 32'(first));
		end
		chk(32'(lacp_en), 32'h0000_00FF);
		q(2'h1, 4'h9, 1'b0);
		chk(32'(res[6:4]), 32'h0000_0005);
		wr(`OFF_CH_CFG, cfg(1'b1, 1'b1, 3'h0));
		q(2'h0, 4'h2, 1'b1);
		chk(32'({res[6:4], lacp_en}), 32'h0002_0000);
		oper_en <= 16'h0008;
		shuffle(1'b1);
		q(2'h0, 4'h0, 1'b0);
		chk(32'(res[4:0]), 32'h0000_0003);
		rc(`OFF_ACTIVE, 32'h0000_0008);
		oper_en <= 16'h0000;
		repeat (3) @(posedge clk);
		q(2'h0, 4'h0, 1'b0);
		chk(32'(res[4]), 32'h0000_0001);
		rc(`OFF_CH_BASE, 32'h0008_0001);
		rc(`OFF_IRQ_STAT, 32'h0000_0002);
		rc(8'h2C, pword(16'h0000, 1'b1));
		oper_en <= 16'hFFFF;
		down_req <= 16'h1020;
		repeat (10) @(posedge clk);
		down_req <= 16'h0000;
		repeat (4) @(posedge clk);
		rc(8'h34, pword(16'h0001, 1'b1));
		rc(8'h50, pword(16'h0001, 1'b0));
		rc(`OFF_IRQ_STAT, 32'h0000_0003);
		rc(`OFF_CH_BASE, 32'h0008_0001);
		wr(`OFF_CH_CFG, cfg(1'b0, 1'b1, 3'h0));
		wr(`OFF_PORT_ADMIN, 32'h0000_FFBF);
		q(2'h0, 4'h1, 1'b0);
		chk(32'(res[6:4]), 32'h0000_0003);
		rc(`OFF_CH_BASE, 32'h0008_0002);
		rc(8'h38, pword(16'h0001, 1'b1));
		rc(8'h34, pword(16'h0001, 1'b1));
		// port 7 leaves; a leave is never refused
		wr(`OFF_MEMBER_CMD, 32'h0000_0007);
		rc(`OFF_MEMBER_CMD, 32'h0000_007F);
		wr(`OFF_CTRL, 32'h0000_0001);
		rc(8'h34, pword(16'h0000, 1'b1));
		rc(`OFF_CH_BASE, 32'h0007_0000);
		rc(8'h50, pword(16'h0000, 1'b0));
		end_sim();
	end
endmodule
bind lag_tracker lag_checker i_lag_checker (.clk(clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .oper_en(oper_en), .tx_valid(tx_valid),
	.tx_out_valid(tx_out_valid), .tx_out_drop(tx_out_drop),
	.rx_valid(rx_valid), .rx_port(rx_port), .rx_lacp(rx_lacp),
	.rx_accept(rx_accept), .rx_drop(rx_drop), .lacp_en(lacp_en));
